// file: verilog/pmt_pkg.sv
package pmt_pkg;

    // register map
    localparam logic [7:0] PMT_TIMING_ADDR  = 8'h8F;
    localparam int         PMT_DELAY_MSB    = 7;
    localparam int         PMT_DELAY_LSB    = 5;
    localparam int         PMT_FREQ_MSB     = 4;
    localparam int         PMT_FREQ_LSB     = 3;
    localparam int         PMT_DEAD_MSB     = 2;
    localparam int         PMT_DEAD_LSB     = 0;
    localparam logic [2:0] PMT_DELAY_RST    = 3'h0;
    localparam logic [1:0] PMT_FREQ_RST     = 2'h0;
    localparam logic [2:0] PMT_DEAD_RST     = 3'h1;

    // modulation clock: one tick per delay/dead step, 25 MHz at 100 MHz clk
    localparam int         PMT_CLK_MHZ      = 100;
    localparam int         PMT_TICK_DIV     = 4;
    // half period of code 00 (390.625 kHz) in ticks: 25 MHz / 390.625k / 2
    localparam int         PMT_HALF_BASE    = 32;
    localparam int         PMT_CNT_W        = 6;

    typedef struct packed {
        logic [2:0] delay;
        logic [1:0] freq;
        logic [2:0] dead;
    } pmt_cfg_s;

endpackage

// file: verilog/pmt_edge_blank.sv
`timescale 1ns/1ps

module pmt_edge_blank
    import pmt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       tick_i,
    input  wire logic       ref_i,
    input  wire logic [2:0] dead_i,
    output logic            open_o
);
    typedef struct packed {
        logic       ref_d;
        logic [2:0] cnt;
        logic       open;
    } pmt_blank_s;

    pmt_blank_s st_r;
    pmt_blank_s st_nxt;

    // window restarts at every reference edge and closes after dead ticks
    always_comb begin
        st_nxt = st_r;
        if (tick_i) begin
            st_nxt.ref_d = ref_i;
            if (ref_i != st_r.ref_d) begin
                st_nxt.cnt  = dead_i;                         // [RULE7]
                st_nxt.open = (dead_i == 3'h0);
            end else if (st_r.cnt != 3'h0) begin
                st_nxt.cnt  = st_r.cnt - 3'h1;
                st_nxt.open = (st_r.cnt == 3'h1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign open_o = st_r.open;
endmodule

// file: verilog/pmt_modulator.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Bits 7:5 of the timing register hold a read/write delay of the demodulation reference.
// (RULE2) The delay accepts 0 to 7 and resets to 0.
// (RULE3) Bits 4:3 pick the square-wave frequency: 390.625k, 781.25k, 1.5625M, 3.125M Hz.
// (RULE4) The frequency resets to 00 and software should avoid codes 10 and 11.
// (RULE5) The emitter is driven by a square wave at the selected frequency.
// (RULE6) The demodulator reference is the emitted wave shifted by the delay.
// (RULE7) Bits 2:0 set a blanking window at each edge of the received signal; the code starts it at each edge of the demodulator reference instead.
// (RULE8) The dead time accepts 0 to 7 and resets to 1.
// (RULE9) Software should not program a dead time of zero; longer values lower the level.
// (RULE10) All fields read back the last written values.
// (RULE11) An over-long dead time also blanks useful signal past the slope.
// (RULE12) One delay or dead-time step is one period of the faster modulator tick.

module pmt_modulator
    import pmt_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       SRST_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic       MEAS_EN_I,
    input  wire logic       RX_I,
    output logic [7:0]      RDATA_O,
    output logic            EMIT_O,
    output logic            DEMOD_REF_O,
    output logic            RX_VALID_O,
    output logic            RX_SAMPLE_O,
    output logic            ACC_UP_O,
    output logic            ACC_DN_O
);

////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        pmt_cfg_s                cfg;
        logic [7:0]              rdata;
        logic [1:0]              div;
        logic                    tick;
        logic [PMT_CNT_W-1:0]    half_cnt;
        logic                    emit;
        logic [7:0]              hist;
        logic                    dref;
        logic [1:0]              rx_sync;
        logic                    en_q;
        logic                    valid;
        logic                    sample;
        logic                    up;
        logic                    dn;
    } pmt_state_s;

    pmt_state_s st_r;
    pmt_state_s st_nxt;
    logic       blank_open;
    logic [PMT_CNT_W-1:0] half_len;

    // higher codes halve the half period [RULE3]
    assign half_len = PMT_CNT_W'(PMT_HALF_BASE >> st_r.cfg.freq);

////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt        = st_r;
        st_nxt.tick   = 1'b0;
        st_nxt.up     = 1'b0;
        st_nxt.dn     = 1'b0;
        st_nxt.rdata  = 8'h00;
        // register port; unmapped reads return zero
        if (WR_I && ADDR_I == PMT_TIMING_ADDR) begin
            st_nxt.cfg.delay = WDATA_I[PMT_DELAY_MSB:PMT_DELAY_LSB]; // [RULE1]
            st_nxt.cfg.freq  = WDATA_I[PMT_FREQ_MSB:PMT_FREQ_LSB];   // [RULE3]
            st_nxt.cfg.dead  = WDATA_I[PMT_DEAD_MSB:PMT_DEAD_LSB];   // [RULE7]
        end
        if (RD_I && ADDR_I == PMT_TIMING_ADDR) begin
            st_nxt.rdata = {st_r.cfg.delay, st_r.cfg.freq,
                            st_r.cfg.dead};                          // [RULE10]
        end
        // step tick generator [RULE12]
        st_nxt.div = st_r.div + 2'h1;
        if (st_r.div == 2'(PMT_TICK_DIV - 1)) begin
            st_nxt.tick = 1'b1;
        end
        // synchroniser: first stage feeds only the second
        st_nxt.rx_sync = {st_r.rx_sync[0], RX_I};
        st_nxt.en_q    = MEAS_EN_I;
        if (!MEAS_EN_I) begin
            st_nxt.half_cnt = '0;
            st_nxt.emit     = 1'b0;
            st_nxt.hist     = 8'h00;
            st_nxt.dref     = 1'b0;
            st_nxt.valid    = 1'b0;
        end else if (st_r.tick) begin
            // square-wave drive [RULE5]
            if (st_r.half_cnt >= half_len - PMT_CNT_W'(1)) begin
                st_nxt.half_cnt = '0;
                st_nxt.emit     = ~st_r.emit;
            end else begin
                st_nxt.half_cnt = st_r.half_cnt + PMT_CNT_W'(1);
            end
            // delayed reference, delay taps of the emit history [RULE6]
            st_nxt.hist = {st_r.hist[6:0], st_r.emit};
            st_nxt.dref = (st_r.cfg.delay == 3'h0) ? st_r.emit
                        : st_r.hist[st_r.cfg.delay - 3'h1];
            // blanked samples are simply dropped, so a long dead time
            // also throws away useful signal after the slope [RULE11]
            st_nxt.valid = blank_open;
            if (blank_open) begin
                st_nxt.sample = st_r.rx_sync[1];
                // phase-sensitive accumulate direction [RULE6]
                st_nxt.up = st_r.rx_sync[1] & st_r.dref;
                st_nxt.dn = st_r.rx_sync[1] & ~st_r.dref;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_r           <= '0;
            st_r.cfg.delay <= PMT_DELAY_RST;                         // [RULE2]
            st_r.cfg.freq  <= PMT_FREQ_RST;                          // [RULE4]
            st_r.cfg.dead  <= PMT_DEAD_RST;                          // [RULE8]
        end else begin
            st_r <= st_nxt;
        end
    end

    pmt_edge_blank u_blank (
        .clk_i  (CLK_I),
        .srst_i (SRST_I | ~st_r.en_q),
        .tick_i (st_r.tick),
        .ref_i  (st_r.dref),
        .dead_i (st_r.cfg.dead),
        .open_o (blank_open)
    );

    assign RDATA_O     = st_r.rdata;
    assign EMIT_O      = st_r.emit;
    assign DEMOD_REF_O = st_r.dref;
    assign RX_VALID_O  = st_r.valid;
    assign RX_SAMPLE_O = st_r.sample;
    assign ACC_UP_O    = st_r.up;
    assign ACC_DN_O    = st_r.dn;
endmodule

// file: verif/pmt_modulator_checker.sv
`timescale 1ns/1ps
module pmt_modulator_checker
    import pmt_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       SRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic       RD_I,
    input wire logic       MEAS_EN_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       EMIT_O,
    input wire logic       DEMOD_REF_O,
    input wire logic       RX_VALID_O,
    input wire logic       ACC_UP_O,
    input wire logic       ACC_DN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    ////////////////////////////////////////////////////////////////////////
    sequence s_bad_read;
        RD_I && ADDR_I != PMT_TIMING_ADDR;
    endsequence
    // stopped modulator edges are not timing edges, so skip them
    sequence s_emit_edge;
        MEAS_EN_I && $changed(EMIT_O);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    bad_read_zero_a: assert property (s_bad_read |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    idle_read_zero_a: assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data outside read slot");
    emit_stop_a: assert property (!MEAS_EN_I [*8] |-> !EMIT_O && !DEMOD_REF_O)
        else $error("modulator not stopped");
    half_period_a: assert property (disable iff (SRST_I || !MEAS_EN_I)
        s_emit_edge |=> $stable(EMIT_O) [*8]) else $error("half period short");
    edge_blank_a: assert property (disable iff (SRST_I || !MEAS_EN_I)
        $changed(DEMOD_REF_O) |-> ##[0:8] !RX_VALID_O) else $error("no blanking");
    acc_excl_a: assert property (!(ACC_UP_O && ACC_DN_O))
        else $error("both accumulate pulses");
    up_pulse_a: assert property (ACC_UP_O |=> !ACC_UP_O)
        else $error("up pulse too long");
    dn_pulse_a: assert property (ACC_DN_O |=> !ACC_DN_O)
        else $error("down pulse too long");
endmodule

bind pmt_modulator pmt_modulator_checker pmt_modulator_checker_inst (.*);

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pmt_pkg::*;
    logic        CLK_I, SRST_I, WR_I, RD_I, MEAS_EN_I, RX_I, rx_inv, e;
    logic [7:0]  ADDR_I, WDATA_I, RDATA_O, q;
    logic        EMIT_O, DEMOD_REF_O, RX_VALID_O, RX_SAMPLE_O, ACC_UP_O, ACC_DN_O;
    int          n_fail, n_tests, n, k, acc, c[2], lg[2], up, dn, sm;
    // address, write data, expected read back
    logic [23:0] rows [6] = '{24'h8FA3A3, 24'h8FFFFF, 24'h8F1818,
                              24'h8F0000, 24'h8F5A5A, 24'h125500};
    pmt_modulator pmt_modulator_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_I = 0;
        forever #5 CLK_I = ~CLK_I;
    end
    // echo of the emitter, optionally inverted to reach the down pulses
    always @(posedge CLK_I) RX_I <= EMIT_O ^ rx_inv;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task tick(input int m);
        repeat (m) @(posedge CLK_I);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a; WDATA_I <= d; WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge CLK_I);
        ADDR_I <= a; RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 q = RDATA_O;
    endtask
    // returns just after an emitter edge, n = length of the half period
    task half;
        e = EMIT_O;
        for (k = 0; k < 600 && EMIT_O === e; k++) tick(1);
        e = EMIT_O;
        for (n = 0; n < 600 && EMIT_O === e; n++) tick(1);
        if (k == 600 || n == 600) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        SRST_I = 1; WR_I = 0; RD_I = 0; MEAS_EN_I = 0; RX_I = 0; rx_inv = 0;
        ADDR_I = 0; WDATA_I = 0; n_fail = 0; n_tests = 0; acc = 0;
        up = 0; dn = 0; sm = 0;
        repeat (5) @(posedge CLK_I);
        SRST_I <= 0;
        #1 chk({EMIT_O, DEMOD_REF_O, RX_VALID_O, RDATA_O}, 0);
        rd(PMT_TIMING_ADDR);
        chk(q, 8'h01);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(q, rows[i][7:0]);
        end
        rd(8'h8F);
        chk(q, 8'h5A);
        // write then read with no gap, data stands one cycle only
        wr(8'h8F, 8'hA3);
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 chk(RDATA_O, 8'hA3);
        tick(1);
        chk(RDATA_O, 8'h00);
        // frequency change only while stopped, a running swap may glitch
        for (int f = 0; f < 4; f++) begin
            MEAS_EN_I <= 0;
            wr(8'h8F, {3'h0, f[1:0], 3'h1});
            tick(8);
            MEAS_EN_I <= 1;
            half;
            half;
            chk(n, (PMT_HALF_BASE >> f) * PMT_TICK_DIV);
        end
        for (int j = 0; j < 2; j++) begin
            MEAS_EN_I <= 0;
            rx_inv <= j[0];
            wr(8'h8F, j ? 8'hE7 : 8'h01); // dead time never 0
            tick(8);
            MEAS_EN_I <= 1;
            half;
            half;
            for (n = 0; n < 600 && DEMOD_REF_O !== EMIT_O; n++) tick(1);
            lg[j] = n;
            c[j] = 0;
            repeat (512) begin
                tick(1);
                c[j] += RX_VALID_O;
                acc += ACC_UP_O | ACC_DN_O;
                up += ACC_UP_O;
                dn += ACC_DN_O;
                sm += RX_SAMPLE_O;
            end
        end
        chk(lg[1] - lg[0], 7 * PMT_TICK_DIV);
        chk(c[1] < c[0], 1);
        chk(acc > 0, 1);
        chk(up > 0, 1);
        chk(dn > 0, 1);
        chk(sm > 0, 1);
        SRST_I <= 1;
        tick(2);
        SRST_I <= 0;
        rd(PMT_TIMING_ADDR);
        chk(q, 8'h01);
        report_and_stop;
    end
endmodule
